// ---- verilog/ccms_pkg.sv ----
package ccms_pkg;

  // ----------------------------------------------------------------
  // Mode codes on the three clock mode strap pins
  // ----------------------------------------------------------------
  localparam int CCMS_STRAP_W = 3;
  localparam logic [2:0] CCMS_MODE_X4 = 3'h7;
  localparam logic [2:0] CCMS_MODE_X3 = 3'h6;
  localparam logic [2:0] CCMS_MODE_X2 = 3'h5;
  localparam logic [2:0] CCMS_MODE_X5 = 3'h4;
  localparam logic [2:0] CCMS_MODE_DIRECT = 3'h3;
  localparam logic [2:0] CCMS_MODE_X1P5 = 3'h2;
  localparam logic [2:0] CCMS_MODE_PRESCALE = 3'h1;
  localparam logic [2:0] CCMS_MODE_X2P5 = 3'h0;
  localparam logic [2:0] CCMS_MODE_RESET = CCMS_MODE_X4;

  // ----------------------------------------------------------------
  // Widths, factors and counts
  // ----------------------------------------------------------------
  localparam int CCMS_PER_W = 10;
  localparam int CCMS_ACC_W = 12;
  localparam int CCMS_F2_W = 4;
  // Twice the multiplication factor, so that 1.5 and 2.5 stay integers.
  localparam logic [3:0] CCMS_F2_X1P5 = 4'h3;
  localparam logic [3:0] CCMS_F2_X2 = 4'h4;
  localparam logic [3:0] CCMS_F2_X2P5 = 4'h5;
  localparam logic [3:0] CCMS_F2_X3 = 4'h6;
  localparam logic [3:0] CCMS_F2_X4 = 4'h8;
  localparam logic [3:0] CCMS_F2_X5 = 4'ha;
  localparam logic [3:0] CCMS_F2_NONE = 4'h0;
  // Core cycles after reset release before the synchronised straps are valid.
  localparam logic [1:0] CCMS_LOCK_WAIT = 2'h2;
  localparam logic [CCMS_PER_W-1:0] CCMS_PER_RESET = 10'h0ff;
  localparam logic [CCMS_PER_W-1:0] CCMS_PER_MAX = 10'h3ff;
  localparam logic [CCMS_PER_W-1:0] CCMS_HALF_RESET = 10'h000;

  typedef enum logic [1:0] {
    CCMS_SRC_HOLD,
    CCMS_SRC_PLL,
    CCMS_SRC_PRESCALE,
    CCMS_SRC_DIRECT
  } ccms_src_t;

  // Twice the CPU clock factor for a mode code; zero where no PLL runs.
  function automatic logic [3:0] ccms_f2_of(input logic [2:0] mode);
    case (mode)
      CCMS_MODE_X4: ccms_f2_of = CCMS_F2_X4;
      CCMS_MODE_X3: ccms_f2_of = CCMS_F2_X3;
      CCMS_MODE_X2: ccms_f2_of = CCMS_F2_X2;
      CCMS_MODE_X5: ccms_f2_of = CCMS_F2_X5;
      CCMS_MODE_X1P5: ccms_f2_of = CCMS_F2_X1P5;
      CCMS_MODE_X2P5: ccms_f2_of = CCMS_F2_X2P5;
      default: ccms_f2_of = CCMS_F2_NONE;
    endcase
  endfunction

  // Oscillator transitions between two realignments of the PLL output.
  // Half-integer factors wait four times the factor, so that a whole number of CPU
  // edges lies between two realignments; otherwise halving the residual
  // phase would drag the CPU clock below its factor.
  function automatic logic [3:0] ccms_realign_of(input logic [2:0] mode);
    logic [3:0] f2;
    f2 = ccms_f2_of(mode);
    ccms_realign_of = f2[0] ? {f2[2:0], 1'b0} : {1'b0, f2[3:1]};
  endfunction

endpackage

// ---- verilog/ccms_osc_sense.sv ----
`timescale 1ns/1ps
`default_nettype none
module ccms_osc_sense (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic osc_in,
  output logic osc_lvl,
  output logic osc_rise,
  output logic osc_fall,
  output logic [ccms_pkg::CCMS_PER_W-1:0] osc_period
);
  import ccms_pkg::*;

  logic sync1;
  logic osc_prev;
  logic [CCMS_PER_W-1:0] per_cnt;

  // --------------------------------------------------------------
  // Pin synchroniser and edge detection
  // --------------------------------------------------------------
  // Two flops bring the oscillator pin in; only the second reads the first,
  // and a third flop keeps the edge marks off the unsettled first stage.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync1 <= 1'b0;
      osc_lvl <= 1'b0;
      osc_prev <= 1'b0;
    end else if (ce) begin
      sync1 <= osc_in;
      osc_lvl <= sync1;
      osc_prev <= osc_lvl;
    end
  end

  // Edge marks last one core cycle, while the settled level and its copy differ.
  assign osc_rise = osc_lvl & ~osc_prev;
  assign osc_fall = ~osc_lvl & osc_prev;

  // --------------------------------------------------------------
  // Oscillator period meter
  // --------------------------------------------------------------
  // Counts core cycles from rise to rise, saturating on a stopped input.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      per_cnt <= '0;
      osc_period <= CCMS_PER_RESET;
    end else if (ce) begin
      if (osc_rise) begin
        per_cnt <= CCMS_PER_W'(1);
        osc_period <= per_cnt;
      end else if (per_cnt != CCMS_PER_MAX) begin
        per_cnt <= per_cnt + CCMS_PER_W'(1);
      end
    end
  end

endmodule
`default_nettype wire

// ---- verilog/ccms_clock_mode_select.sv ----
`timescale 1ns/1ps
`default_nettype none
module ccms_clock_mode_select (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic osc_in,
  input wire logic [ccms_pkg::CCMS_STRAP_W-1:0] clock_mode_strap_pins,
  output logic cpu_clk,
  output logic cpu_edge,
  output logic cpu_rise,
  output logic cpu_fall,
  output logic [ccms_pkg::CCMS_PER_W-1:0] clock_half_period,
  output logic [ccms_pkg::CCMS_STRAP_W-1:0] clock_mode,
  output logic [ccms_pkg::CCMS_F2_W-1:0] clock_factor_x2,
  output logic pll_enable,
  output logic mode_locked
);
  import ccms_pkg::*;

  logic [2:0] strap_s1;
  logic [2:0] strap_s2;
  logic [1:0] lock_cnt;
  ccms_src_t src;
  logic osc_lvl;
  logic osc_rise;
  logic osc_fall;
  logic [CCMS_PER_W-1:0] osc_period;
  logic [CCMS_PER_W-1:0] period_est;
  logic [CCMS_ACC_W-1:0] acc;
  logic [CCMS_ACC_W-1:0] next_acc;
  logic pll_toggle;
  logic [3:0] realign_cnt;
  logic realign_now;
  logic next_cpu_clk;
  logic [CCMS_PER_W-1:0] half_cnt;

  // ----------------------------------------------------------------
  // Oscillator input
  // ----------------------------------------------------------------
  ccms_osc_sense u_osc (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .osc_in(osc_in),
    .osc_lvl(osc_lvl),
    .osc_rise(osc_rise),
    .osc_fall(osc_fall),
    .osc_period(osc_period)
  );

  // ----------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------
  // The straps pass two flops; the code is caught once they are valid.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      strap_s1 <= CCMS_MODE_RESET;
      strap_s2 <= CCMS_MODE_RESET;
    end else if (ce) begin
      strap_s1 <= clock_mode_strap_pins;
      strap_s2 <= strap_s1;
    end
  end

  // Latch once after release, then ignore the pins until the next reset.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lock_cnt <= '0;
      mode_locked <= 1'b0;
      clock_mode <= CCMS_MODE_RESET;
      clock_factor_x2 <= CCMS_F2_NONE;
      pll_enable <= 1'b0;
      src <= CCMS_SRC_HOLD;
    end else if (ce && !mode_locked) begin
      if (lock_cnt != CCMS_LOCK_WAIT) begin
        lock_cnt <= lock_cnt + 2'h1;
      end else begin
        mode_locked <= 1'b1;
        clock_mode <= strap_s2;
        clock_factor_x2 <= ccms_f2_of(strap_s2);
        pll_enable <= ccms_f2_of(strap_s2) != CCMS_F2_NONE;
        case (strap_s2)
          CCMS_MODE_PRESCALE: src <= CCMS_SRC_PRESCALE;
          CCMS_MODE_DIRECT: src <= CCMS_SRC_DIRECT;
          default: src <= CCMS_SRC_PLL;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Digital PLL
  // ----------------------------------------------------------------
  // The period estimate creeps one step per oscillator rise, so the
  // CPU clock frequency never jumps when the input period changes.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      period_est <= CCMS_PER_RESET;
    end else if (ce && osc_rise) begin
      if (osc_period > period_est) begin
        period_est <= period_est + CCMS_PER_W'(1);
      end else if (osc_period < period_est) begin
        period_est <= period_est - CCMS_PER_W'(1);
      end
    end
  end

  // Phase accumulator adds twice the factor per core cycle; one CPU edge
  // is due each time it passes one oscillator period.
  always_comb begin
    next_acc = acc + CCMS_ACC_W'(clock_factor_x2);
    pll_toggle = 1'b0;
    if (next_acc >= CCMS_ACC_W'(period_est)) begin
      next_acc = next_acc - CCMS_ACC_W'(period_est);
      pll_toggle = 1'b1;
    end
  end

  assign realign_now = (osc_rise | osc_fall) &&
                       (realign_cnt + 4'h1 >= ccms_realign_of(clock_mode));

  // Every ccms_realign_of(clock_mode) oscillator transitions the residual phase is halved,
  // pulling the CPU clock toward the input clock without a step.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      acc <= '0;
      realign_cnt <= '0;
    end else if (ce && src == CCMS_SRC_PLL) begin
      if (realign_now) begin
        realign_cnt <= '0;
        acc <= {1'b0, next_acc[CCMS_ACC_W-1:1]};
      end else begin
        acc <= next_acc;
        if (osc_rise | osc_fall) begin
          realign_cnt <= realign_cnt + 4'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // CPU clock source selection
  // ----------------------------------------------------------------
  always_comb begin
    case (src)
      CCMS_SRC_PLL: next_cpu_clk = cpu_clk ^ pll_toggle;
      CCMS_SRC_PRESCALE: next_cpu_clk = cpu_clk ^ osc_rise;
      CCMS_SRC_DIRECT: next_cpu_clk = osc_lvl;
      default: next_cpu_clk = 1'b0;
    endcase
  end

  // The clock and its edge marks leave the block from flops.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cpu_clk <= 1'b0;
      cpu_edge <= 1'b0;
      cpu_rise <= 1'b0;
      cpu_fall <= 1'b0;
    end else if (ce) begin
      cpu_clk <= next_cpu_clk;
      cpu_edge <= next_cpu_clk ^ cpu_clk;
      cpu_rise <= next_cpu_clk & ~cpu_clk;
      cpu_fall <= ~next_cpu_clk & cpu_clk;
    end
  end

  // ----------------------------------------------------------------
  // Half period measurement
  // ----------------------------------------------------------------
  // Core cycles from one CPU edge to the next, reported at each edge.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      half_cnt <= '0;
      clock_half_period <= CCMS_HALF_RESET;
    end else if (ce) begin
      if (next_cpu_clk != cpu_clk) begin
        half_cnt <= '0;
        clock_half_period <= half_cnt + CCMS_PER_W'(1);
      end else if (half_cnt != CCMS_PER_MAX) begin
        half_cnt <= half_cnt + CCMS_PER_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_straps_held;
    mode_locked && $past(mode_locked);
  endsequence

  property p_edge_marks;
    @(posedge core_clk) disable iff (rst || !ce)
      $past(ce) |-> (cpu_edge == (cpu_clk != $past(cpu_clk)));
  endproperty
  a_edge_marks: assert property (p_edge_marks) else $error("edge mark wrong");

  property p_rise_fall;
    @(posedge core_clk) disable iff (rst || !ce)
      (cpu_rise |-> cpu_clk && cpu_edge) and (cpu_fall |-> !cpu_clk && cpu_edge);
  endproperty
  a_rise_fall: assert property (p_rise_fall) else $error("rise or fall mark wrong");

  property p_half_period;
    @(posedge core_clk) disable iff (rst || !ce)
      ($past(ce) && cpu_edge) |-> clock_half_period == $past(half_cnt) + CCMS_PER_W'(1);
  endproperty
  a_half_period: assert property (p_half_period) else $error("half period wrong");

  property p_strap_capture;
    @(posedge core_clk) disable iff (rst || !ce)
      $rose(mode_locked) |-> clock_mode == $past(strap_s2);
  endproperty
  a_strap_capture: assert property (p_strap_capture) else $error("strap not captured");

  property p_factor;
    @(posedge core_clk) disable iff (rst || !ce)
      mode_locked |-> clock_factor_x2 == ccms_f2_of(clock_mode);
  endproperty
  a_factor: assert property (p_factor) else $error("factor mismatch");

  property p_prescale;
    @(posedge core_clk) disable iff (rst || !ce)
      (src == CCMS_SRC_PRESCALE && $past(src) == CCMS_SRC_PRESCALE && $past(ce)) |->
        (cpu_edge == $past(osc_rise));
  endproperty
  a_prescale: assert property (p_prescale) else $error("prescaler edge wrong");

  property p_pll_enable;
    @(posedge core_clk) disable iff (rst || !ce)
      mode_locked |-> pll_enable ==
        (clock_mode != CCMS_MODE_PRESCALE && clock_mode != CCMS_MODE_DIRECT);
  endproperty
  a_pll_enable: assert property (p_pll_enable) else $error("pll enable wrong");

  property p_realign;
    @(posedge core_clk) disable iff (rst || !ce)
      src == CCMS_SRC_PLL |-> realign_cnt < ccms_realign_of(clock_mode);
  endproperty
  a_realign: assert property (p_realign) else $error("realign count overrun");

  property p_direct;
    @(posedge core_clk) disable iff (rst || !ce)
      (src == CCMS_SRC_DIRECT && $past(src) == CCMS_SRC_DIRECT && $past(ce)) |->
        cpu_clk == $past(osc_lvl);
  endproperty
  a_direct: assert property (p_direct) else $error("direct drive mismatch");

  property p_mode_hold;
    @(posedge core_clk) disable iff (rst || !ce)
      s_straps_held |-> $stable(clock_mode) && $stable(src);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed after lock");

endmodule
`default_nettype wire

// ---- test/ccms_osc_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Oscillator source model
// ----------------------------------------------------------------
module ccms_osc_model (
  input wire logic [15:0] high_ns,
  input wire logic [15:0] low_ns,
  output logic osc_out
);
  // Free-running source; a 1 ns offset keeps its edges off the core edges.
  initial begin
    osc_out = 1'b0;
    #1;
    forever begin
      #(low_ns);
      osc_out = 1'b1;
      #(high_ns);
      osc_out = 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- test/tb_ccms_clock_mode_select.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_errors++; $display("CHECK FAILED at %0t: got %h expected %h", $time, (a), (b)); end end
module tb_ccms_clock_mode_select;
  import ccms_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and design
  // ----------------------------------------------------------------
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [2:0] clock_mode_strap_pins = 3'h7;
  logic [15:0] high_ns = 16'h0008;
  logic [15:0] low_ns = 16'h0020;
  logic osc_in;
  logic cpu_clk, cpu_edge, cpu_rise, cpu_fall, pll_enable, mode_locked;
  logic [9:0] clock_half_period;
  logic [2:0] clock_mode;
  logic [3:0] clock_factor_x2;
  int n_errors = 0;
  int n_compared = 0;
  // Twice the factor for each code, indexed by the code.
  logic [3:0] exp_f2 [8] = '{4'h5, 4'h0, 4'h3, 4'h0, 4'ha, 4'h4, 4'h6, 4'h8};

  // The core clock runs at 250 MHz.
  always #2 core_clk = ~core_clk;

  ccms_osc_model i_ccms_osc_model (.high_ns(high_ns), .low_ns(low_ns), .osc_out(osc_in));

  ccms_clock_mode_select i_ccms_clock_mode_select (
    .core_clk(core_clk), .rst(rst), .ce(ce), .osc_in(osc_in),
    .clock_mode_strap_pins(clock_mode_strap_pins), .cpu_clk(cpu_clk),
    .cpu_edge(cpu_edge), .cpu_rise(cpu_rise), .cpu_fall(cpu_fall),
    .clock_half_period(clock_half_period), .clock_mode(clock_mode),
    .clock_factor_x2(clock_factor_x2), .pll_enable(pll_enable),
    .mode_locked(mode_locked)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic wrap_up();
    if (n_errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Holds reset for 11 cycles with the straps driven, then checks the latch moment.
  task automatic do_reset(input logic [2:0] code);
    @(posedge core_clk);
    rst <= 1'b1;
    clock_mode_strap_pins <= code;
    repeat (10) @(posedge core_clk);
    #1;
    `CHK(clock_mode, 3'h7)
    `CHK(mode_locked, 1'b0)
    `CHK(cpu_clk, 1'b0)
    @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    #1;
    `CHK(mode_locked, 1'b0)
    @(posedge core_clk);
    #1;
    `CHK(mode_locked, 1'b0)
    @(posedge core_clk);
    #1;
    `CHK(mode_locked, 1'b1)
    `CHK(clock_mode, code)
  endtask

  // Judges every CPU clock edge after the first two, over 400 cycles, against fixed half periods.
  task automatic check_halves(input logic [9:0] h_rise, input logic [9:0] h_fall,
                              input logic [9:0] h_sum);
    int seen;
    logic [9:0] prev;
    seen = 0;
    prev = 10'h000;
    for (int i = 0; i < 400; i++) begin
      @(posedge core_clk);
      #1;
      `CHK(cpu_edge, cpu_rise | cpu_fall)
      if (cpu_edge === 1'b1) begin
        seen++;
        if (seen > 2) begin
          `CHK(clock_half_period, (cpu_rise ? h_rise : h_fall))
          `CHK(10'(clock_half_period + prev), h_sum)
        end
        prev = clock_half_period;
      end
    end
    `CHK(seen > 20, 1'b1)
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Every code gives its factor and PLL choice; later strap changes are ignored.
  task automatic test_modes();
    for (int c = 0; c < 8; c++) begin
      do_reset(3'(c));
      `CHK(clock_factor_x2, exp_f2[c])
      `CHK(pll_enable, (c != 1 && c != 3))
      @(posedge core_clk);
      clock_mode_strap_pins <= ~3'(c);
      repeat (6) @(posedge core_clk);
      #1;
      `CHK(clock_mode, 3'(c))
    end
  endtask

  // Prescaler: each half period is one 40 ns oscillator period, skewed duty.
  task automatic test_prescale();
    high_ns <= 16'h0008;
    low_ns <= 16'h0020;
    do_reset(3'h1);
    `CHK(pll_enable, 1'b0)
    check_halves(10'h00a, 10'h00a, 10'h014);
  endtask

  // Direct drive: halves follow a 20/40 ns duty and pair to one period.
  task automatic test_direct();
    high_ns <= 16'h0014;
    low_ns <= 16'h0028;
    do_reset(3'h3);
    @(posedge core_clk);
    clock_mode_strap_pins <= 3'h7;
    check_halves(10'h00a, 10'h005, 10'h00f);
  endtask

  // Clock enable low freezes the CPU clock, its half period and the lock.
  task automatic test_freeze();
    logic held_clk;
    logic [9:0] held_half;
    @(posedge core_clk);
    ce <= 1'b0;
    @(posedge core_clk);
    #1;
    held_clk = cpu_clk;
    held_half = clock_half_period;
    repeat (40) @(posedge core_clk);
    #1;
    `CHK(cpu_clk, held_clk)
    `CHK(clock_half_period, held_half)
    `CHK(mode_locked, 1'b1)
    `CHK(clock_mode, 3'h3)
    @(posedge core_clk);
    ce <= 1'b1;
  endtask

  // PLL: after settling, the edge count over ten 400 ns periods matches 2F per period.
  task automatic test_pll(input logic [2:0] code, input int lo, input int hi);
    int n;
    n = 0;
    high_ns <= 16'h00c8;
    low_ns <= 16'h00c8;
    do_reset(code);
    `CHK(pll_enable, 1'b1)
    repeat (20000) @(posedge core_clk);
    for (int i = 0; i < 1000; i++) begin
      @(posedge core_clk);
      #1;
      if (cpu_edge === 1'b1) n++;
    end
    `CHK((n >= lo && n <= hi), 1'b1)
  endtask

  // Watchdog sized well above the expected run of about 43000 cycles.
  initial begin
    #(60000 * 4);
    n_errors++;
    wrap_up();
  end

  // Main sequence.
  initial begin
    test_modes();
    test_prescale();
    test_direct();
    test_freeze();
    test_pll(3'h7, 78, 82);
    test_pll(3'h0, 48, 52);
    wrap_up();
  end
endmodule
`default_nettype wire
